// >>> bench/apc_cfg_bank_props.sv
// Purpose: Concurrent checks on the first-loop analog configuration bank.
// Assumes: One clock, clk_sys, with asynchronous active-low rst_n.
// Notes: Decoded outputs are checked one cycle after their raw fields.
`timescale 1ns/1ns
module apc_cfg_bank_props (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [2:0] pump_current_code,
	input wire logic [1:0] series_resistor_select,
	input wire logic [1:0] parallel_capacitor_select,
	input wire logic second_pole_select,
	input wire logic lock_count_precision,
	input wire logic lock_override,
	input wire logic manual_oscillator_select,
	input wire logic [4:0] first_osc_lock_code,
	input wire logic [4:0] second_osc_lock_code,
	input wire logic synthesizer_only_mode,
	input wire logic [9:0] pump_current_ua,
	input wire logic [10:0] series_resistor_ohm,
	input wire logic [7:0] parallel_capacitor_pf,
	input wire logic [10:0] post_resistor_ohm,
	input wire logic [7:0] post_capacitor_pf,
	input wire logic first_oscillator_manual_en,
	input wire logic second_oscillator_manual_en,
	input wire logic [4:0] applied_lock_code
);
	// All raw fields together; they may only move on a write's ack edge.
	wire [21:0] fields = {pump_current_code, series_resistor_select,
		parallel_capacitor_select, second_pole_select, lock_count_precision,
		lock_override, manual_oscillator_select, first_osc_lock_code,
		second_osc_lock_code, synthesizer_only_mode};
	wire [4:0] man_code = manual_oscillator_select ?
		first_osc_lock_code : second_osc_lock_code;

	// The tables are written out here so a slip in the design's copy shows.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack lasted more than one cycle");
	a_ack_after_req: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	a_ack_needs_req: assert property (
		wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");
	a_upper_data_zero: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_fields_hold: assert property (
		!(wb_ack_o && wb_we_i) |=> $stable(fields))
		else $error("field changed without a write");
	a_pump_decode: assert property ($past(rst_n) |->
		pump_current_ua ==
		10'h06E * ({7'h00, $past(pump_current_code)} + 10'h001))
		else $error("pump current wrong");
	a_res_decode: assert property ($past(rst_n) |->
		series_resistor_ohm == ($past(series_resistor_select) == 2'h0 ?
		11'h14A : $past(series_resistor_select) == 2'h1 ? 11'h280 :
		$past(series_resistor_select) == 2'h2 ? 11'h4B0 : 11'h6FE))
		else $error("series resistor wrong");
	a_cap_decode: assert property ($past(rst_n) |->
		parallel_capacitor_pf == ($past(parallel_capacitor_select) == 2'h0 ?
		8'h28 : $past(parallel_capacitor_select) == 2'h1 ? 8'h50 :
		$past(parallel_capacitor_select) == 2'h2 ? 8'h8C : 8'hC8))
		else $error("parallel capacitor wrong");
	a_post_decode: assert property ($past(rst_n) |->
		post_capacitor_pf == 8'h28 && post_resistor_ohm ==
		($past(second_pole_select) ? 11'h62C : 11'h1F1))
		else $error("second pole wrong");
	a_manual_enables: assert property ($past(rst_n) |->
		first_oscillator_manual_en ==
		$past(lock_override && manual_oscillator_select) &&
		second_oscillator_manual_en ==
		$past(lock_override && !manual_oscillator_select))
		else $error("manual oscillator enable wrong");
	a_applied_code: assert property ($past(rst_n) |->
		applied_lock_code == ($past(lock_override) ? $past(man_code) : 5'h00))
		else $error("applied lock code wrong");

	c_write_acked: cover property (wb_ack_o && wb_we_i);
	c_manual_first: cover property (first_oscillator_manual_en);
	c_manual_second: cover property (second_oscillator_manual_en);
	c_synth_on: cover property (synthesizer_only_mode);
endmodule : apc_cfg_bank_props

bind apc_cfg_bank apc_cfg_bank_props i_apc_cfg_bank_props (
	.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .pump_current_code(pump_current_code),
	.series_resistor_select(series_resistor_select),
	.parallel_capacitor_select(parallel_capacitor_select),
	.second_pole_select(second_pole_select),
	.lock_count_precision(lock_count_precision),
	.lock_override(lock_override),
	.manual_oscillator_select(manual_oscillator_select),
	.first_osc_lock_code(first_osc_lock_code),
	.second_osc_lock_code(second_osc_lock_code),
	.synthesizer_only_mode(synthesizer_only_mode),
	.pump_current_ua(pump_current_ua),
	.series_resistor_ohm(series_resistor_ohm),
	.parallel_capacitor_pf(parallel_capacitor_pf),
	.post_resistor_ohm(post_resistor_ohm),
	.post_capacitor_pf(post_capacitor_pf),
	.first_oscillator_manual_en(first_oscillator_manual_en),
	.second_oscillator_manual_en(second_oscillator_manual_en),
	.applied_lock_code(applied_lock_code));

// >>> bench/apc_cfg_bank_tb.sv
// Purpose: Self-checking bench for the first-loop configuration bank.
// Assumes: Classic Wishbone, byte address 0x2B0 plus four per register.
// Notes: Reads queue their expectation; a monitor compares on ack.
`timescale 1ns/1ns
module apc_cfg_bank_tb;
	localparam logic [7:0] RST_V [4] = '{8'h8B, 8'h02, 8'h2B, 8'h00};
	localparam logic [7:0] WMSK [4] = '{8'hFF, 8'h0B, 8'h3F, 8'h1F};
	localparam logic [31:0] RES_T [4] = '{32'h14A, 32'h280, 32'h4B0, 32'h6FE};
	localparam logic [31:0] CAP_T [4] = '{32'h28, 32'h50, 32'h8C, 32'hC8};
	logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [11:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, mon_exp;
	logic [1:0] digital_loop_state_field, res_sel, cap_sel;
	logic [2:0] pump_code;
	logic pole, lcnt, ovr, osel, synth, en1, en2;
	logic [4:0] code1, code2, applied;
	logic [9:0] pump_ua;
	logic [10:0] res_ohm, post_ohm;
	logic [7:0] cap_pf, post_pf;
	logic [7:0] st_exp;
	logic [7:0] mdl [4];
	logic [31:0] exp_q [$];
	int miscompares, num_checks;

	apc_cfg_bank i_apc_cfg_bank (.clk_sys(clk_sys), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.digital_loop_state_field(digital_loop_state_field),
		.pump_current_code(pump_code), .series_resistor_select(res_sel),
		.parallel_capacitor_select(cap_sel), .second_pole_select(pole),
		.lock_count_precision(lcnt), .lock_override(ovr),
		.manual_oscillator_select(osel), .first_osc_lock_code(code1),
		.second_osc_lock_code(code2), .synthesizer_only_mode(synth),
		.pump_current_ua(pump_ua), .series_resistor_ohm(res_ohm),
		.parallel_capacitor_pf(cap_pf), .post_resistor_ohm(post_ohm),
		.post_capacitor_pf(post_pf), .first_oscillator_manual_en(en1),
		.second_oscillator_manual_en(en2), .applied_lock_code(applied));

	// Free-running 100 MHz clock.
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		if (miscompares == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb_cycle(input logic [11:0] adr, input logic we,
		input logic [7:0] dat, input logic sel0);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= {3'($urandom), sel0};
		wb_dat_i <= {24'($urandom), dat};
		// No cycle count is assumed; only the watchdog ends a lost answer.
		do
			@(posedge clk_sys);
		while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_cycle

	// Index 4 is an unmapped word just past the bank; index 20 is status.
	task automatic reg_write(input int i, input logic [7:0] d, input logic s0);
		wb_cycle(12'h2B0 + 12'(4 * i), 1'b1, d, s0);
		if (s0 && i < 4)
			mdl[i] = d & WMSK[i];
	endtask : reg_write

	task automatic reg_read(input int i);
		exp_q.push_back(i < 4 ? {24'h0, mdl[i]} :
			{24'h0, i == 20 ? st_exp : 8'h00});
		wb_cycle(12'h2B0 + 12'(4 * i), 1'b0, 8'h00, 1'b1);
	endtask : reg_read

	// Read data is taken at the ack edge, with the request still standing.
	always @(posedge clk_sys)
	begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
		begin
			mon_exp = exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF;
			check("rdata", wb_dat_o, mon_exp);
		end
	end

	// Decoded outputs trail the raw fields by one cycle, so wait two.
	task automatic chk_outputs();
		logic [7:0] r0, r1, r2, r3;
		repeat (2) @(posedge clk_sys);
		#1;
		r0 = mdl[0];
		r1 = mdl[1];
		r2 = mdl[2];
		r3 = mdl[3];
		check("pump", 32'(pump_code), 32'(r0[7:5]));
		check("pump_ua", 32'(pump_ua), 32'h6E * (32'(r0[7:5]) + 32'h1));
		check("res", 32'(res_sel), 32'(r0[4:3]));
		check("res_ohm", 32'(res_ohm), RES_T[r0[4:3]]);
		check("cap", 32'(cap_sel), 32'(r0[2:1]));
		check("cap_pf", 32'(cap_pf), CAP_T[r0[2:1]]);
		check("pole", 32'(pole), 32'(r0[0]));
		check("post", 32'({post_ohm, post_pf}),
			r0[0] ? 32'h62C28 : 32'h1F128);
		check("lcnt", 32'(lcnt), 32'(r1[1]));
		check("ovr", 32'(ovr), 32'(r1[0]));
		check("synth", 32'(synth), 32'(r1[3]));
		check("osel", 32'(osel), 32'(r2[5]));
		check("code1", 32'(code1), 32'(r2[4:0]));
		check("code2", 32'(code2), 32'(r3[4:0]));
		check("en", 32'({en1, en2}),
			32'({r1[0] & r2[5], r1[0] & ~r2[5]}));
		check("applied", 32'(applied), !r1[0] ? 32'h0 :
			32'(r2[5] ? r2[4:0] : r3[4:0]));
	endtask : chk_outputs

	// Reset, then check defaults at the ports and over the bus.
	task automatic do_reset();
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		mdl = RST_V;
		chk_outputs();
		for (int i = 0; i < 5; i++)
			reg_read(i);
	endtask : do_reset

	// Watchdog cuts a hang short well past the expected run length.
	initial
	begin
		#200000;
		miscompares++;
		report_and_stop();
	end

	// Main sequence: defaults, every pump and filter code, manual modes,
	// random traffic with reserved, unmapped and lane-masked writes.
	initial
	begin
		rst_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 12'h000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		digital_loop_state_field = 2'h0;
		miscompares = 0;
		num_checks = 0;
		void'($urandom(32'hBD1F521A));
		do_reset();
		for (int v = 0; v < 256; v++)
		begin
			reg_write(0, 8'(v), 1'b1);
			chk_outputs();
		end
		for (int k = 0; k < 8; k++)
		begin
			// Synth mode goes with the forced free-run loop state.
			digital_loop_state_field <= k[2] ? 2'h3 : 2'($urandom);
			reg_write(1, {4'h0, k[2], 2'h1, k[0]}, 1'b1);
			reg_write(2, {2'h0, k[1], 5'($urandom)}, 1'b1);
			reg_write(3, 8'($urandom) & 8'h1F, 1'b1);
			chk_outputs();
		end
		reg_write(1, 8'h00, 1'b1);
		for (int n = 0; n < 80; n++)
		begin
			digital_loop_state_field <= 2'($urandom);
			if ($urandom_range(0, 1) == 0)
				reg_write($urandom_range(0, 4), 8'($urandom),
					$urandom_range(0, 3) != 0);
			else
				reg_read($urandom_range(0, 4));
			chk_outputs();
		end
		// Status word: sticky flags are write-one-to-clear, and a cause
		// that still holds wins over the clear in the same cycle.
		digital_loop_state_field <= 2'h0;
		reg_write(1, 8'h01, 1'b1);
		reg_write(20, 8'h03, 1'b1);
		st_exp = {3'h0, 1'b0, mdl[2][5], 1'b1, 2'h0};
		reg_read(20);
		reg_write(3, 8'hE5, 1'b1);
		reg_write(1, 8'h08, 1'b1);
		st_exp = 8'h13;
		reg_read(20);
		reg_write(20, 8'h03, 1'b1);
		st_exp = 8'h12;
		reg_read(20);
		digital_loop_state_field <= 2'h3;
		reg_write(20, 8'h02, 1'b1);
		st_exp = 8'h10;
		reg_read(20);
		chk_outputs();
		do_reset();
		// Let the monitor take the last read's ack before counting notes.
		@(posedge clk_sys);
		check("pending", 32'(exp_q.size()), 32'h0);
		report_and_stop();
	end
endmodule : apc_cfg_bank_tb

// >>> core/apc_byte_reg.sv
// Purpose: One 8-bit configuration register with a writable-bit mask.
// Assumes: Asynchronous active-low reset to RST_VAL.
// Notes: Bits outside WMASK stay zero whatever software writes.
`timescale 1ns/1ns
module apc_byte_reg #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] WMASK = 8'hFF
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	output logic [7:0] q
);
	logic [7:0] q_nxt;

	// Reserved positions never store, so they read back as zero.
	assign q_nxt = wr_en ? (wdata & WMASK) : q;

	// The register keeps its value until the next write.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			q <= RST_VAL & WMASK;
		else
			q <= q_nxt;
	end
endmodule : apc_byte_reg

// >>> core/apc_cfg_bank.sv
// Purpose: Configuration bank of the first loop's analog section.
// Assumes: Registers reached over classic Wishbone on clk_sys.
// Notes: Outputs are static levels held until software rewrites them.
// Notes on behaviour
// - A 3-bit pump current code resets to 100 and picks 110 uA per step.
// - A 2-bit series resistor code resets to 01 and picks 330 to 1790 ohm.
// - A 2-bit parallel capacitor code resets to 01 and picks 40 to 200 pF.
// - A second pole bit resets to 1 and picks the 497 or 1580 ohm post.
// - A lock count bit resets to 1; 0 means 1 ppm and 1 means 16 ppm.
// - A lock override bit resets to 0; 1 selects manual lock operation.
// - An oscillator select bit resets to 1; 1 is the first oscillator.
// - The first oscillator lock code resets to 01011, used only in manual.
// - The second oscillator lock code resets to 0, used only in manual.
// - A synthesizer mode bit resets to 0; 1 runs from the crystal alone.
// - Reserved bits are written as zero and their read value is undefined; here they never store and read back as zero.
`timescale 1ns/1ns
module apc_cfg_bank #(
	parameter logic [1:0] FREERUN_STATE = 2'h3
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] digital_loop_state_field,
	output logic [2:0] pump_current_code,
	output logic [1:0] series_resistor_select,
	output logic [1:0] parallel_capacitor_select,
	output logic second_pole_select,
	output logic lock_count_precision,
	output logic lock_override,
	output logic manual_oscillator_select,
	output logic [4:0] first_osc_lock_code,
	output logic [4:0] second_osc_lock_code,
	output logic synthesizer_only_mode,
	output logic [9:0] pump_current_ua,
	output logic [10:0] series_resistor_ohm,
	output logic [7:0] parallel_capacitor_pf,
	output logic [10:0] post_resistor_ohm,
	output logic [7:0] post_capacitor_pf,
	output logic first_oscillator_manual_en,
	output logic second_oscillator_manual_en,
	output logic [4:0] applied_lock_code
);
	localparam int NREG = 4;
	localparam logic [NREG-1:0][9:0] REG_IDX = {
		apc_pkg::APC_IDX_OSC2_LOCK, apc_pkg::APC_IDX_OSC1_LOCK,
		apc_pkg::APC_IDX_LOCK_MODE, apc_pkg::APC_IDX_PUMP_FILTER};
	localparam logic [NREG-1:0][7:0] REG_RST = {
		apc_pkg::APC_REG3_RST, apc_pkg::APC_REG2_RST,
		apc_pkg::APC_REG1_RST, apc_pkg::APC_REG0_RST};
	localparam logic [NREG-1:0][7:0] REG_MASK = {
		apc_pkg::APC_REG3_MASK, apc_pkg::APC_REG2_MASK,
		apc_pkg::APC_REG1_MASK, apc_pkg::APC_REG0_MASK};

	apc_reg_if rif ();

	logic [NREG-1:0][7:0] reg_q;
	logic [NREG-1:0] reg_hit;
	logic [NREG-1:0] reg_wr;
	logic [7:0] cfg_rdata;
	logic status_hit;
	logic [7:0] status_rd;
	logic rsvd_seen_r;
	logic rsvd_seen_nxt;
	logic synth_warn_r;
	logic synth_warn_nxt;
	logic rsvd_set;
	logic synth_set;
	logic status_wr;
	logic [2:0] pump_code;
	logic [1:0] res_code;
	logic [1:0] cap_code;
	logic pole_bit;
	logic lcnt_bit;
	logic ovr_bit;
	logic osc_sel_bit;
	logic synth_bit;
	logic [4:0] code1;
	logic [4:0] code2;
	logic [9:0] pump_steps;
	logic [9:0] pump_ua_nxt;
	logic [10:0] res_ohm_nxt;
	logic [7:0] cap_pf_nxt;
	logic [10:0] post_ohm_nxt;
	logic osc1_en_nxt;
	logic osc2_en_nxt;
	logic [4:0] lock_code_nxt;

	// Bus slave: decodes Wishbone cycles into single-cycle bank accesses.
	apc_wb_slave u_wb (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.rif(rif.bus)
	);

	// One masked byte register per configuration word.
	for (genvar g = 0; g < NREG; g++)
	begin : g_reg
		assign reg_hit[g] = (rif.idx == REG_IDX[g]);
		assign reg_wr[g] = rif.wr & reg_hit[g];
		apc_byte_reg #(
			.RST_VAL(REG_RST[g]),
			.WMASK(REG_MASK[g])
		) u_reg (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.wr_en(reg_wr[g]),
			.wdata(rif.wdata),
			.q(reg_q[g])
		);
	end

	// Read mux; an unmapped index answers zero and ignores writes.
	assign status_hit = (rif.idx == apc_pkg::APC_IDX_STATUS);
	assign cfg_rdata = reg_hit[0] ? reg_q[0] :
		reg_hit[1] ? reg_q[1] :
		reg_hit[2] ? reg_q[2] :
		reg_hit[3] ? reg_q[3] : 8'h00;
	assign rif.rdata = status_hit ? status_rd : cfg_rdata;

	// Field extraction from the stored words.
	assign pump_code = reg_q[0][apc_pkg::APC_PUMP_LSB +: 3];
	assign res_code = reg_q[0][apc_pkg::APC_RES_LSB +: 2];
	assign cap_code = reg_q[0][apc_pkg::APC_CAP_LSB +: 2];
	assign pole_bit = reg_q[0][apc_pkg::APC_POLE_BIT];
	assign synth_bit = reg_q[1][apc_pkg::APC_SYNTH_BIT];
	assign lcnt_bit = reg_q[1][apc_pkg::APC_LCNT_BIT];
	assign ovr_bit = reg_q[1][apc_pkg::APC_OVR_BIT];
	assign osc_sel_bit = reg_q[2][apc_pkg::APC_OSC_SEL_BIT];
	assign code1 = reg_q[2][apc_pkg::APC_CODE_LSB +: 5];
	assign code2 = reg_q[3][apc_pkg::APC_CODE_LSB +: 5];

	// Raw fields go straight out; they already come from flip-flops.
	assign pump_current_code = pump_code;
	assign series_resistor_select = res_code;
	assign parallel_capacitor_select = cap_code;
	assign second_pole_select = pole_bit;
	assign lock_count_precision = lcnt_bit;
	assign lock_override = ovr_bit;
	assign manual_oscillator_select = osc_sel_bit;
	assign first_osc_lock_code = code1;
	assign second_osc_lock_code = code2;
	assign synthesizer_only_mode = synth_bit;

	// Pump current is code plus one times the step, 110 uA to 880 uA.
	assign pump_steps = {7'h00, pump_code} + 10'h001;
	assign pump_ua_nxt = 10'(pump_steps * apc_pkg::APC_PUMP_STEP_UA);

	// Series resistor and parallel capacitor lookups, in code order.
	assign res_ohm_nxt = (res_code == 2'h0) ? apc_pkg::APC_RES_330_OHM :
		(res_code == 2'h1) ? apc_pkg::APC_RES_640_OHM :
		(res_code == 2'h2) ? apc_pkg::APC_RES_1200_OHM :
		apc_pkg::APC_RES_1790_OHM;
	assign cap_pf_nxt = (cap_code == 2'h0) ? apc_pkg::APC_CAP_40_PF :
		(cap_code == 2'h1) ? apc_pkg::APC_CAP_80_PF :
		(cap_code == 2'h2) ? apc_pkg::APC_CAP_140_PF :
		apc_pkg::APC_CAP_200_PF;

	// The post capacitor is fixed; only the post resistor follows the bit.
	assign post_ohm_nxt = pole_bit ? apc_pkg::APC_POST_1580_OHM :
		apc_pkg::APC_POST_497_OHM;

	// Manual lock: oscillator choice and code apply only under override.
	// In automatic mode the digital loop owns the code, so we present zero.
	assign osc1_en_nxt = ovr_bit & osc_sel_bit;
	assign osc2_en_nxt = ovr_bit & ~osc_sel_bit;
	assign lock_code_nxt = !ovr_bit ? 5'h00 :
		osc_sel_bit ? code1 : code2;

	// Decoded analog values are registered so they change glitch-free.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pump_current_ua <= 10'h000;
			series_resistor_ohm <= 11'h000;
			parallel_capacitor_pf <= 8'h00;
			post_resistor_ohm <= 11'h000;
			post_capacitor_pf <= 8'h00;
		end
		else
		begin
			pump_current_ua <= pump_ua_nxt;
			series_resistor_ohm <= res_ohm_nxt;
			parallel_capacitor_pf <= cap_pf_nxt;
			post_resistor_ohm <= post_ohm_nxt;
			post_capacitor_pf <= apc_pkg::APC_POST_CAP_PF;
		end
	end

	// Manual lock outputs, registered like the analog values.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			first_oscillator_manual_en <= 1'b0;
			second_oscillator_manual_en <= 1'b0;
			applied_lock_code <= 5'h00;
		end
		else
		begin
			first_oscillator_manual_en <= osc1_en_nxt;
			second_oscillator_manual_en <= osc2_en_nxt;
			applied_lock_code <= lock_code_nxt;
		end
	end

	// Sticky warnings. A write with reserved bits set is flagged, and so is
	// synth mode left on while the digital loop is not forced to free-run.
	// The state input is on clk_sys already, so it needs no synchroniser.
	assign rsvd_set = |(reg_wr[0] ? (rif.wdata & ~REG_MASK[0]) : 8'h00) |
		|(reg_wr[1] ? (rif.wdata & ~REG_MASK[1]) : 8'h00) |
		|(reg_wr[2] ? (rif.wdata & ~REG_MASK[2]) : 8'h00) |
		|(reg_wr[3] ? (rif.wdata & ~REG_MASK[3]) : 8'h00);
	assign synth_set = synth_bit &
		(digital_loop_state_field != FREERUN_STATE);
	assign status_wr = rif.wr & status_hit;

	// Write one to clear; a new event in the same cycle wins.
	assign rsvd_seen_nxt = rsvd_set | (rsvd_seen_r &
		~(status_wr & rif.wdata[apc_pkg::APC_ST_RSVD_BIT]));
	assign synth_warn_nxt = synth_set | (synth_warn_r &
		~(status_wr & rif.wdata[apc_pkg::APC_ST_SYNTH_BIT]));

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rsvd_seen_r <= 1'b0;
			synth_warn_r <= 1'b0;
		end
		else
		begin
			rsvd_seen_r <= rsvd_seen_nxt;
			synth_warn_r <= synth_warn_nxt;
		end
	end

	// Status word: sticky flags below, live mode state above.
	always_comb
	begin
		status_rd = 8'h00;
		status_rd[apc_pkg::APC_ST_RSVD_BIT] = rsvd_seen_r;
		status_rd[apc_pkg::APC_ST_SYNTH_BIT] = synth_warn_r;
		status_rd[apc_pkg::APC_ST_MANUAL_BIT] = ovr_bit;
		status_rd[apc_pkg::APC_ST_OSC1_BIT] = first_oscillator_manual_en;
		status_rd[apc_pkg::APC_ST_MODE_BIT] = synth_bit;
	end
endmodule : apc_cfg_bank

// >>> core/apc_pkg.sv
// Purpose: Shared constants for the first-loop analog configuration bank.
// Assumes: 8-bit registers, one per 32-bit Wishbone word, index = adr/4.
// Notes: Reset values are built from the per-field values below.
package apc_pkg;
	localparam int APC_IDX_W = 10;
	localparam int APC_REG_W = 8;
	// Register indices; the byte address is four times the index.
	localparam logic [9:0] APC_IDX_PUMP_FILTER = 10'h0AC;
	localparam logic [9:0] APC_IDX_LOCK_MODE = 10'h0AD;
	localparam logic [9:0] APC_IDX_OSC1_LOCK = 10'h0AE;
	localparam logic [9:0] APC_IDX_OSC2_LOCK = 10'h0AF;
	localparam logic [9:0] APC_IDX_STATUS = 10'h0C0;
	// Field positions.
	localparam int APC_PUMP_LSB = 5;
	localparam int APC_RES_LSB = 3;
	localparam int APC_CAP_LSB = 1;
	localparam int APC_POLE_BIT = 0;
	localparam int APC_SYNTH_BIT = 3;
	localparam int APC_LCNT_BIT = 1;
	localparam int APC_OVR_BIT = 0;
	localparam int APC_OSC_SEL_BIT = 5;
	localparam int APC_CODE_LSB = 0;
	localparam int APC_ST_RSVD_BIT = 0;
	localparam int APC_ST_SYNTH_BIT = 1;
	localparam int APC_ST_MANUAL_BIT = 2;
	localparam int APC_ST_OSC1_BIT = 3;
	localparam int APC_ST_MODE_BIT = 4;
	// Field reset values.
	localparam logic [2:0] APC_PUMP_RST = 3'h4;
	localparam logic [1:0] APC_RES_RST = 2'h1;
	localparam logic [1:0] APC_CAP_RST = 2'h1;
	localparam logic APC_POLE_RST = 1'h1;
	localparam logic APC_SYNTH_RST = 1'h0;
	localparam logic APC_LCNT_RST = 1'h1;
	localparam logic APC_OVR_RST = 1'h0;
	localparam logic APC_OSC_SEL_RST = 1'h1;
	localparam logic [4:0] APC_CODE1_RST = 5'h0B;
	localparam logic [4:0] APC_CODE2_RST = 5'h00;
	// Whole-register reset values and writable-bit masks.
	localparam logic [7:0] APC_REG0_RST =
		{APC_PUMP_RST, APC_RES_RST, APC_CAP_RST, APC_POLE_RST};
	localparam logic [7:0] APC_REG1_RST =
		{4'h0, APC_SYNTH_RST, 1'h0, APC_LCNT_RST, APC_OVR_RST};
	localparam logic [7:0] APC_REG2_RST =
		{2'h0, APC_OSC_SEL_RST, APC_CODE1_RST};
	localparam logic [7:0] APC_REG3_RST = {3'h0, APC_CODE2_RST};
	localparam logic [7:0] APC_REG0_MASK = 8'hFF;
	localparam logic [7:0] APC_REG1_MASK = 8'h0B;
	localparam logic [7:0] APC_REG2_MASK = 8'h3F;
	localparam logic [7:0] APC_REG3_MASK = 8'h1F;
	// Analog values selected by the codes.
	localparam logic [9:0] APC_PUMP_STEP_UA = 10'h06E;
	localparam logic [10:0] APC_RES_330_OHM = 11'h14A;
	localparam logic [10:0] APC_RES_640_OHM = 11'h280;
	localparam logic [10:0] APC_RES_1200_OHM = 11'h4B0;
	localparam logic [10:0] APC_RES_1790_OHM = 11'h6FE;
	localparam logic [7:0] APC_CAP_40_PF = 8'h28;
	localparam logic [7:0] APC_CAP_80_PF = 8'h50;
	localparam logic [7:0] APC_CAP_140_PF = 8'h8C;
	localparam logic [7:0] APC_CAP_200_PF = 8'hC8;
	localparam logic [10:0] APC_POST_497_OHM = 11'h1F1;
	localparam logic [10:0] APC_POST_1580_OHM = 11'h62C;
	localparam logic [7:0] APC_POST_CAP_PF = APC_CAP_40_PF;
endpackage : apc_pkg

// >>> core/apc_reg_if.sv
// Purpose: Carries decoded register accesses from the bus slave to the bank.
// Assumes: One clock; wr is a one-cycle pulse.
// Notes: rdata is combinational from the bank for the presented index.
`timescale 1ns/1ns
interface apc_reg_if;
	logic wr;
	logic [9:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport bus (output wr, output idx, output wdata, input rdata);
	modport bank (input wr, input idx, input wdata, output rdata);
endinterface : apc_reg_if

// >>> core/apc_wb_slave.sv
// Purpose: Classic Wishbone slave that turns bus cycles into bank accesses.
// Assumes: 32-bit data, byte lane 0 carries the 8-bit registers.
// Notes: Ack comes one cycle after the request; writes land on the ack edge.
`timescale 1ns/1ns
module apc_wb_slave (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	apc_reg_if.bus rif
);
	logic req;
	logic ack_nxt;
	logic [31:0] dat_nxt;

	// A request is new while ack has not yet been given for it.
	assign req = wb_cyc_i & wb_stb_i;
	assign ack_nxt = req & ~wb_ack_o;
	assign dat_nxt = ack_nxt ? {24'h000000, rif.rdata} : wb_dat_o;

	// The write fires at the edge where the master samples ack high.
	assign rif.wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign rif.idx = wb_adr_i[11:2];
	assign rif.wdata = wb_dat_i[7:0];

	// Ack lasts one cycle so that a held request is answered only once.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= ack_nxt;
			wb_dat_o <= dat_nxt;
		end
	end
endmodule : apc_wb_slave
